// *** cdu_current_dac_update_control.sv ***
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - disabled: pin is plain gpio
// - enabled: drivers, pull-up off, pin to dac
// - enabled requests bias generator
// - update source bits 6:4, reset 111
// - mode 111: high write loads latch
// - mode 111: low write only held
// - modes 000-011 pick timer 0-3 overflow
// - timer modes: hold until selected overflow
// - modes 100-110: rise, fall, any strobe edge
// - strobe modes: hold until selected edge
// - left-justified: high 9:2, low 7:6 1:0
// - fullscale 00 half, 01 one, 1x two ma
// - reset fullscale is 2 ma
// - low bits 5:0 read zero, ignored
// - control bits 3:2 read zero, ignored
module cdu_current_dac_update_control
   import cdu_pkg::*;
#(
   parameter int TIMERS = TIMER_COUNT
) (
   input  wire logic                  mclk,
   input  wire logic                  reset,
   input  wire cdu_sfr_req_type       sfr_req,
   output logic [BYTE_WIDTH-1:0]      sfr_rdata,
   output logic                       sfr_hit,
   input  wire logic [TIMERS-1:0]     timer_overflow,
   input  wire logic                  external_convert_strobe,
   output logic [DATA_WIDTH-1:0]      dac_latch,
   output cdu_range_type              fullscale_range,
   output logic                       dac_enable_bit,
   output cdu_pin_ctl_type            pin_ctl,
   output logic                       latch_pulse
);

   initial begin
      if (TIMERS != TIMER_COUNT) begin
         $error("timer count must be four");
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // register state
   logic [BYTE_WIDTH-1:0] dac_data_low_byte;
   logic [BYTE_WIDTH-1:0] dac_data_high_byte;
   logic [BYTE_WIDTH-1:0] dac_control;
   logic [BYTE_WIDTH-1:0] next_dac_data_low_byte;
   logic [BYTE_WIDTH-1:0] next_dac_data_high_byte;
   logic [BYTE_WIDTH-1:0] next_dac_control;
   logic [DATA_WIDTH-1:0] next_dac_latch;
   logic [BYTE_WIDTH-1:0] next_sfr_rdata;
   logic                  next_sfr_hit;
   logic                  next_latch_pulse;

   logic [2:0]            update_source_select;
   logic [1:0]            fullscale_current_select;
   logic                  write_low;
   logic                  write_high;
   logic                  write_ctl;
   logic                  strobe_rise;
   logic                  strobe_fall;
   logic                  trigger;
   logic [DATA_WIDTH-1:0] held_word;

   assign update_source_select     = dac_control[CTL_SOURCE_MSB:CTL_SOURCE_LSB];
   assign fullscale_current_select = dac_control[CTL_FULLSCALE_MSB:CTL_FULLSCALE_LSB];
   assign dac_enable_bit           = dac_control[CTL_ENABLE_BIT];

   assign write_low  = sfr_req.write && (sfr_req.addr == ADDR_DATA_LOW);
   assign write_high = sfr_req.write && (sfr_req.addr == ADDR_DATA_HIGH);
   assign write_ctl  = sfr_req.write && (sfr_req.addr == ADDR_CONTROL);

   //////////////////////////////////////////////////////////////////////////
   // strobe edge detection
   cdu_edge_detect #(
      .STAGES (SYNC_STAGES)
   ) u_edge (
      .mclk       (mclk),
      .reset      (reset),
      .strobe_in  (external_convert_strobe),
      .rise_pulse (strobe_rise),
      .fall_pulse (strobe_fall)
   );

   //////////////////////////////////////////////////////////////////////////
   // trigger selection
   always_comb begin
      trigger = 1'b0;
      unique case (update_source_select)
         SRC_TIMER0:      trigger = timer_overflow[0];
         SRC_TIMER1:      trigger = timer_overflow[1];
         SRC_TIMER2:      trigger = timer_overflow[2];
         SRC_TIMER3:      trigger = timer_overflow[3];
         SRC_STROBE_RISE: trigger = strobe_rise;
         SRC_STROBE_FALL: trigger = strobe_fall;
         SRC_STROBE_ANY:  trigger = strobe_rise | strobe_fall;
         SRC_HIGH_WRITE:  trigger = write_high;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // held word, with a high write in the trigger cycle taking its new byte
   always_comb begin
      held_word = {dac_data_high_byte,
                   dac_data_low_byte[LOW_DATA_MSB:LOW_DATA_LSB]};
      if (write_high) begin
         held_word[DATA_WIDTH-1:2] = sfr_req.wdata;
      end
      if (write_low) begin
         held_word[1:0] = sfr_req.wdata[LOW_DATA_MSB:LOW_DATA_LSB];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // register writes, latch transfer and read data
   always_comb begin
      next_dac_data_low_byte  = dac_data_low_byte;
      next_dac_data_high_byte = dac_data_high_byte;
      next_dac_control        = dac_control;
      next_dac_latch          = dac_latch;
      next_latch_pulse        = trigger;
      next_sfr_rdata          = 8'h00;
      next_sfr_hit            = 1'b0;
      if (write_low) begin
         next_dac_data_low_byte = sfr_req.wdata & LOW_RW_MASK;
      end
      if (write_high) begin
         next_dac_data_high_byte = sfr_req.wdata;
      end
      if (write_ctl) begin
         next_dac_control = sfr_req.wdata & CONTROL_RW_MASK;
      end
      if (trigger) begin
         next_dac_latch = held_word;
      end
      if (sfr_req.read) begin
         unique case (sfr_req.addr)
            ADDR_DATA_LOW: begin
               next_sfr_rdata = dac_data_low_byte & LOW_RW_MASK;
               next_sfr_hit   = 1'b1;
            end
            ADDR_DATA_HIGH: begin
               next_sfr_rdata = dac_data_high_byte;
               next_sfr_hit   = 1'b1;
            end
            ADDR_CONTROL: begin
               next_sfr_rdata = dac_control & CONTROL_RW_MASK;
               next_sfr_hit   = 1'b1;
            end
            default: begin
               next_sfr_rdata = 8'h00;
               next_sfr_hit   = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         dac_data_low_byte  <= RESET_DATA_LOW;
         dac_data_high_byte <= RESET_DATA_HIGH;
         dac_control        <= RESET_CONTROL;
         dac_latch          <= '0;
         latch_pulse        <= 1'b0;
         sfr_rdata          <= 8'h00;
         sfr_hit            <= 1'b0;
      end else begin
         dac_data_low_byte  <= next_dac_data_low_byte;
         dac_data_high_byte <= next_dac_data_high_byte;
         dac_control        <= next_dac_control;
         dac_latch          <= next_dac_latch;
         latch_pulse        <= next_latch_pulse;
         sfr_rdata          <= next_sfr_rdata;
         sfr_hit            <= next_sfr_hit;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // range decode and pin takeover
   always_comb begin
      if (fullscale_current_select[1]) begin
         fullscale_range = cdu_range_two_ma;
      end else if (fullscale_current_select[0]) begin
         fullscale_range = cdu_range_one_ma;
      end else begin
         fullscale_range = cdu_range_half_ma;
      end
   end

   always_comb begin
      pin_ctl.pin_analog      = dac_enable_bit;
      pin_ctl.pin_digital_off = dac_enable_bit;
      pin_ctl.pin_pullup_off  = dac_enable_bit;
      pin_ctl.bias_request    = dac_enable_bit;
   end

endmodule

// *** cdu_pkg.sv ***
package cdu_pkg;

   localparam int          DATA_WIDTH        = 10;
   localparam int          BYTE_WIDTH        = 8;
   localparam int          TIMER_COUNT       = 4;
   localparam int          SYNC_STAGES       = 2;

   localparam logic [7:0]  ADDR_DATA_LOW     = 8'h96;
   localparam logic [7:0]  ADDR_DATA_HIGH    = 8'h97;
   localparam logic [7:0]  ADDR_CONTROL      = 8'hb9;

   localparam int          CTL_ENABLE_BIT    = 7;
   localparam int          CTL_SOURCE_MSB    = 6;
   localparam int          CTL_SOURCE_LSB    = 4;
   localparam int          CTL_FULLSCALE_MSB = 1;
   localparam int          CTL_FULLSCALE_LSB = 0;
   localparam int          LOW_DATA_MSB      = 7;
   localparam int          LOW_DATA_LSB      = 6;

   localparam logic [7:0]  RESET_DATA_LOW    = 8'h00;
   localparam logic [7:0]  RESET_DATA_HIGH   = 8'h00;
   localparam logic [7:0]  RESET_CONTROL     = 8'h72;
   localparam logic [7:0]  CONTROL_RW_MASK   = 8'hf3;
   localparam logic [7:0]  LOW_RW_MASK       = 8'hc0;

   localparam logic [2:0]  SRC_TIMER0        = 3'h0;
   localparam logic [2:0]  SRC_TIMER1        = 3'h1;
   localparam logic [2:0]  SRC_TIMER2        = 3'h2;
   localparam logic [2:0]  SRC_TIMER3        = 3'h3;
   localparam logic [2:0]  SRC_STROBE_RISE   = 3'h4;
   localparam logic [2:0]  SRC_STROBE_FALL   = 3'h5;
   localparam logic [2:0]  SRC_STROBE_ANY    = 3'h6;
   localparam logic [2:0]  SRC_HIGH_WRITE    = 3'h7;

   typedef enum logic [1:0] {
      cdu_range_half_ma,
      cdu_range_one_ma,
      cdu_range_two_ma
   } cdu_range_type;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cdu_sfr_req_type;

   typedef struct packed {
      logic       bias_request;
      logic       pin_analog;
      logic       pin_digital_off;
      logic       pin_pullup_off;
   } cdu_pin_ctl_type;

endpackage

// *** cdu_edge_detect.sv ***
module cdu_edge_detect
   import cdu_pkg::*;
#(
   parameter int STAGES = SYNC_STAGES
) (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic strobe_in,
   output logic      rise_pulse,
   output logic      fall_pulse
);

   initial begin
      if (STAGES < 2) begin
         $error("cdu_edge_detect needs at least two stages");
      end
   end

   logic [STAGES:0] sync;
   logic [STAGES:0] next_sync;

   ////////////////////////////////////////////////////////////////////////
   // synchroniser chain plus one history stage
   always_comb begin
      next_sync = {sync[STAGES-1:0], strobe_in};
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         sync <= '0;
      end else begin
         sync <= next_sync;
      end
   end

   assign rise_pulse = sync[STAGES-1] & ~sync[STAGES];
   assign fall_pulse = ~sync[STAGES-1] & sync[STAGES];

endmodule

// *** cdu_props.sv ***
module cdu_props
   import cdu_pkg::*;
#(
   parameter int TIMERS = TIMER_COUNT
) (
   input wire logic                  mclk,
   input wire logic                  reset,
   input wire cdu_sfr_req_type       sfr_req,
   input wire logic [BYTE_WIDTH-1:0] sfr_rdata,
   input wire logic                  sfr_hit,
   input wire logic [TIMERS-1:0]     timer_overflow,
   input wire logic                  external_convert_strobe,
   input wire logic [DATA_WIDTH-1:0] dac_latch,
   input wire cdu_range_type         fullscale_range,
   input wire logic                  dac_enable_bit,
   input wire cdu_pin_ctl_type       pin_ctl,
   input wire logic                  latch_pulse
);
   logic [7:0] ctl;
   logic [2:0] md;
   logic       s;
   logic       rd;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   assign md = ctl[6:4];
   assign s = external_convert_strobe;
   assign rd = sfr_req.read;
   // shadow of the control register
   always_ff @(posedge mclk) begin
      if (reset) ctl <= RESET_CONTROL;
      else if (sfr_req.write && sfr_req.addr == ADDR_CONTROL) ctl <= sfr_req.wdata & CONTROL_RW_MASK;
   end
   //////////////////////////////////////////////////////////////////////////////
   property p_pin; pin_ctl == {4{dac_enable_bit}} && dac_enable_bit == ctl[7]; endproperty
   a_pin: assert property (p_pin) else $error("pin control wrong");
   property p_rng; fullscale_range == (ctl[1] ? cdu_range_two_ma :
      ctl[0] ? cdu_range_one_ma : cdu_range_half_ma); endproperty
   a_rng: assert property (p_rng) else $error("range decode wrong");
   property p_hi; sfr_req.write && sfr_req.addr == ADDR_DATA_HIGH && md == SRC_HIGH_WRITE
      |=> latch_pulse && dac_latch[9:2] == $past(sfr_req.wdata); endproperty
   a_hi: assert property (p_hi) else $error("high write load wrong");
   property p_tmr; md < 3'h4 && timer_overflow[md[1:0]] |=> latch_pulse; endproperty
   a_tmr: assert property (p_tmr) else $error("timer load missing");
   property p_stb; (md == SRC_STROBE_RISE && $rose(s)) || (md == SRC_STROBE_FALL && $fell(s))
      || (md == SRC_STROBE_ANY && $changed(s)) |-> ##[2:4] latch_pulse; endproperty
   a_stb: assert property (p_stb) else $error("strobe load missing");
   property p_chg; $changed(dac_latch) |-> latch_pulse; endproperty
   a_chg: assert property (p_chg) else $error("latch moved alone");
   property p_rdc; rd && sfr_req.addr == ADDR_CONTROL |=> sfr_hit && sfr_rdata == $past(ctl);
   endproperty
   a_rdc: assert property (p_rdc) else $error("control read wrong");
   property p_rdl; rd && sfr_req.addr == ADDR_DATA_LOW |=> sfr_hit && sfr_rdata[5:0] == 6'h00;
   endproperty
   a_rdl: assert property (p_rdl) else $error("low read wrong");
   //////////////////////////////////////////////////////////////////////////////
   cover property (sfr_req.write && sfr_req.addr == ADDR_DATA_HIGH && md == SRC_HIGH_WRITE);
   cover property (md < 3'h4 && latch_pulse);
   cover property (md == SRC_STROBE_ANY && latch_pulse);
endmodule

bind cdu_current_dac_update_control cdu_props #(.TIMERS(TIMERS)) props_u (.*);

// *** cdu_partner.sv ***
module cdu_partner (
   input  wire logic       mclk,
   input  wire logic       reset,
   input  wire logic       tmr_go,
   input  wire logic [1:0] tmr_sel,
   input  wire logic       strobe_lvl,
   output logic [3:0]      timer_overflow,
   output logic            external_convert_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   // timers pulse one cycle, strobe pin follows request
   always_ff @(posedge mclk) begin
      timer_overflow <= (reset || !tmr_go) ? 4'h0 : 4'h1 << tmr_sel;
      external_convert_strobe <= reset ? 1'b0 : strobe_lvl;
   end
endmodule

// *** cdu_current_dac_update_control_tb_top.sv ***
module cdu_current_dac_update_control_tb_top import cdu_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic            mclk = 0;
   logic            reset = 1;
   cdu_sfr_req_type sfr_req = '0;
   logic            tmr_go = 0;
   logic [1:0]      tmr_sel = 0;
   logic            strobe_lvl = 0;
   logic [7:0]      sfr_rdata, lo, hi;
   logic [3:0]      timer_overflow;
   logic [9:0]      dac_latch, expw;
   cdu_range_type   fullscale_range;
   cdu_pin_ctl_type pin_ctl;
   logic            sfr_hit, external_convert_strobe, dac_enable_bit, latch_pulse;
   int              miscompares = 0, checks = 0, seed = 76244;
   always #4 mclk = ~mclk;
   cdu_current_dac_update_control dut_u (.*);
   cdu_partner partner_u (.*);
   //////////////////////////////////////////////////////////////////////////////
   function automatic logic [9:0] exp_word(input logic [7:0] h, input logic [7:0] l);
      return {h, l[7:6]};
   endfunction
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_word(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: latch %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) sfr_req <= '{1'b1, 1'b0, a, d};
      @(posedge mclk) sfr_req <= '0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
      @(posedge mclk) sfr_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge mclk) sfr_req <= '0;
      #1;
      cmp_byte(sfr_rdata, e);
      cmp_byte({7'h00, sfr_hit}, {7'h00, h});
   endtask
   task automatic fire(input logic [1:0] sel);
      @(posedge mclk) {tmr_go, tmr_sel} <= {1'b1, sel};
      @(posedge mclk) tmr_go <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic strb(input logic v);
      @(posedge mclk) strobe_lvl <= v;
      repeat (6) @(posedge mclk);
      #1;
   endtask
   task automatic print_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      rd(ADDR_CONTROL, RESET_CONTROL, 1'b1);
      rd(ADDR_DATA_LOW, 8'h00, 1'b1);
      rd(ADDR_DATA_HIGH, 8'h00, 1'b1);
      cmp_byte({6'h00, fullscale_range}, 8'h02);
      cmp_byte({4'h0, pin_ctl}, 8'h00);
      cmp_byte({7'h00, dac_enable_bit}, 8'h00);
      wr(ADDR_CONTROL, 8'hff);
      rd(ADDR_CONTROL, 8'hf3, 1'b1);
      cmp_byte({4'h0, pin_ctl}, 8'h0f);
      cmp_byte({7'h00, dac_enable_bit}, 8'h01);
      wr(ADDR_DATA_LOW, 8'hff);
      rd(ADDR_DATA_LOW, 8'hc0, 1'b1);
      rd(8'h55, 8'h00, 1'b0);
      for (int r = 0; r < 4; r++) begin
         wr(ADDR_CONTROL, {6'h3c, 2'(r)});
         cmp_byte({6'h00, fullscale_range}, (r > 1) ? 8'h02 : 8'(r));
      end
      lo = 8'h00;
      expw = 10'h000;
      wr(ADDR_DATA_LOW, lo);
      for (int i = 0; i < 8; i++) begin
         hi = (i == 0) ? 8'hff : 8'($random(seed));
         if (i > 3) lo = 8'($random(seed));
         if (i > 3) wr(ADDR_DATA_LOW, lo);
         cmp_word(dac_latch, expw);
         wr(ADDR_DATA_HIGH, hi);
         expw = exp_word(hi, lo);
         cmp_word(dac_latch, expw);
      end
      for (int m = 0; m < 7; m++) begin
         wr(ADDR_CONTROL, {1'b1, 3'(m), 4'h2});
         for (int e = 1; e >= 0; e--) begin
            hi = 8'($random(seed));
            lo = 8'($random(seed));
            wr(ADDR_DATA_LOW, lo);
            wr(ADDR_DATA_HIGH, hi);
            cmp_word(dac_latch, expw);
            if (m < 4) fire(2'(m + e));
            else strb(e[0]);
            if (m < 4 ? e == 0 : (m == 6 || m == 5 - e)) expw = exp_word(hi, lo);
            cmp_word(dac_latch, expw);
         end
      end
      print_verdict;
   end
   initial begin
      repeat (3000) @(posedge mclk);
      miscompares++;
      print_verdict;
   end
endmodule
